/* File: hdl/pss_pkg.sv */
// Purpose: constants for the power-up soft-start sequencer
// Assumes: 250 MHz reference clock, references in 0.25 mV steps
// Notes:   register offsets are byte addresses on APB
package pss_pkg;
	localparam int          CLK_MHZ          = 250;
	localparam int          START_DELAY_US   = 100;
	localparam int          START_DELAY_CYC  = START_DELAY_US * CLK_MHZ;
	localparam int          US_CYC           = CLK_MHZ;
	localparam int          SLOPE_UV_PER_US  = 3250;
	localparam int          REF_LSB_UV       = 250;
	localparam int          REF_W            = 13;
	localparam logic [12:0] RAMP_STEP        = 13'(SLOPE_UV_PER_US / REF_LSB_UV);
	localparam logic [7:0]  OFS_CTRL         = 8'h00;
	localparam logic [7:0]  OFS_STATUS       = 8'h04;
	localparam logic [7:0]  OFS_CORE_REF     = 8'h08;
	localparam logic [7:0]  OFS_NB_REF       = 8'h0C;
	localparam int          CTRL_HOLD_BIT    = 0;
	localparam logic        CTRL_HOLD_RST    = 1'b0;
	localparam int          ST_STATE_LSB     = 0;
	localparam int          ST_SERIAL_BIT    = 3;
	localparam int          ST_PHASES_LSB    = 4;
	localparam int          ST_PGOOD_BIT     = 7;
	localparam int          ST_CGATE_BIT     = 8;
	localparam int          ST_NGATE_BIT     = 9;
	localparam int          ST_SVI_PINS_LSB  = 12;
	typedef enum logic [2:0] {PSS_OFF, PSS_DETECT, PSS_DELAY, PSS_RAMP, PSS_DONE} pss_state_t;
endpackage : pss_pkg

/* File: hdl/pss_sequencer.sv */
// Purpose: power-up soft-start sequencer for a dual-output buck controller
// Assumes: comparator flags are asynchronous, target words come from same-clock decoders
// Notes:   APB slave answers with zero wait states
// Overview of operation
// - start only with enable, bias and both driver supplies valid and the hold bit clear
// - driver, enable and phase checks happen only after bias reset flag is up
// - both driver supply reset flags must be up; hysteresis lives in the comparators
// - enable comparator low holds shutdown; threshold lives in analog front end
// - enable rising edge latches serial or parallel mode from interface_select_pin
// - phase sense pins are sampled before soft-start
// - phase4 high gives three phases; both high gives two phases
// - parallel mode keeps secondary rail off and ramps core only
// - serial mode samples fixed enable, data and clock pins at enable
// - serial targets stay fixed until enable low or bias reset
// - soft-start start loads both targets into the reference generator
// - fixed 100 us delay before references rise
// - references ramp at 3.25 mV per us toward targets
// - power good rises once references reach their targets
// - feedback above ramping reference keeps that rail's gates off
// - gates enable once reference passes feedback
// - feedback above target whole ramp enables gates at soft-start end
// - power good stays low in shutdown and soft-start
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module pss_sequencer #(
	parameter int START_DELAY_CYC = pss_pkg::START_DELAY_CYC
) (
	input  wire logic                      i_ref_clk,
	input  wire logic                      i_rstn,
	input  wire logic                      i_bias_por_ok,
	input  wire logic                      i_core_driver_supply_ok,
	input  wire logic                      i_nb_driver_supply_ok,
	input  wire logic                      i_enable_cmp,
	input  wire logic                      i_interface_select_pin,
	input  wire logic                      i_phase3_sense_neg,
	input  wire logic                      i_phase4_sense_neg,
	input  wire logic                      i_fixed_vid_enable,
	input  wire logic                      i_serial_vid_data,
	input  wire logic                      i_serial_vid_clock,
	input  wire logic                      i_core_fb_above_ref,
	input  wire logic                      i_nb_fb_above_ref,
	input  wire logic [pss_pkg::REF_W-1:0] i_parallel_target,
	input  wire logic [pss_pkg::REF_W-1:0] i_serial_core_target,
	input  wire logic [pss_pkg::REF_W-1:0] i_serial_nb_target,
	input  wire logic                      i_psel,
	input  wire logic                      i_penable,
	input  wire logic                      i_pwrite,
	input  wire logic [7:0]                i_paddr,
	input  wire logic [31:0]               i_pwdata,
	output logic                           o_pready,
	output logic                           o_pslverr,
	output logic [31:0]                    o_prdata,
	output logic [pss_pkg::REF_W-1:0]      o_core_ref,
	output logic [pss_pkg::REF_W-1:0]      o_nb_ref,
	output logic                           o_core_gate_en,
	output logic                           o_nb_gate_en,
	output logic                           o_nb_regulator_en,
	output logic                           o_serial_vid_mode,
	output logic [2:0]                     o_phase_count,
	output logic                           o_power_good_out
);
	localparam int SW = 12;
	localparam logic [12:0] US_LAST = 13'(pss_pkg::US_CYC - 1);
	localparam logic [15:0] DLY_LAST = 16'(START_DELAY_CYC - 1);
	localparam pss_pkg::pss_state_t PSS_OFF    = pss_pkg::PSS_OFF;
	localparam pss_pkg::pss_state_t PSS_DETECT = pss_pkg::PSS_DETECT;
	localparam pss_pkg::pss_state_t PSS_DELAY  = pss_pkg::PSS_DELAY;
	localparam pss_pkg::pss_state_t PSS_RAMP   = pss_pkg::PSS_RAMP;
	localparam pss_pkg::pss_state_t PSS_DONE   = pss_pkg::PSS_DONE;

	function automatic logic [pss_pkg::REF_W-1:0] ramp_next(
		input logic [pss_pkg::REF_W-1:0] ref_v,
		input logic [pss_pkg::REF_W-1:0] tgt
	);
		logic [pss_pkg::REF_W:0] sum;
		sum = {1'b0, ref_v} + {1'b0, pss_pkg::RAMP_STEP};
		ramp_next = (sum >= {1'b0, tgt}) ? tgt : sum[pss_pkg::REF_W-1:0];
	endfunction : ramp_next

	logic [SW-1:0]               meta_q;
	logic [SW-1:0]               sync_q;
	logic                        en_prev_q;
	pss_pkg::pss_state_t         state_q;
	logic                        serial_q;
	logic [2:0]                  svi_pins_q;
	logic [pss_pkg::REF_W-1:0]   svi_core_q;
	logic [pss_pkg::REF_W-1:0]   svi_nb_q;
	logic [pss_pkg::REF_W-1:0]   core_tgt_q;
	logic [pss_pkg::REF_W-1:0]   nb_tgt_q;
	logic [pss_pkg::REF_W-1:0]   core_ref_q;
	logic [pss_pkg::REF_W-1:0]   nb_ref_q;
	logic [2:0]                  phases_q;
	logic [15:0]                 dly_q;
	logic [12:0]                 us_q;
	logic                        cgate_q;
	logic                        ngate_q;
	logic                        pgood_q;
	logic                        hold_q;
	logic [31:0]                 prdata_q;

	wire bias_s  = sync_q[0];
	wire cdrv_s  = sync_q[1];
	wire ndrv_s  = sync_q[2];
	wire en_s    = sync_q[3];
	wire sel_s   = sync_q[4];
	wire ph3_s   = sync_q[5];
	wire ph4_s   = sync_q[6];
	wire cfb_s   = sync_q[9+1];
	wire nfb_s   = sync_q[11];
	wire en_rise = bias_s & en_s & ~en_prev_q;
	wire supplies_ok = bias_s & cdrv_s & ndrv_s & en_s;
	wire start_ok = supplies_ok & ~hold_q;
	wire us_tick  = (us_q == US_LAST);
	wire refs_done = (core_ref_q == core_tgt_q) & (nb_ref_q == nb_tgt_q);
	wire in_soft  = (state_q == PSS_DELAY) | (state_q == PSS_RAMP);
	wire apb_acc  = i_psel & i_penable;
	wire apb_wr   = apb_acc & i_pwrite;
	wire hit_ctrl = (i_paddr == pss_pkg::OFS_CTRL);
	wire hit_stat = (i_paddr == pss_pkg::OFS_STATUS);
	wire hit_cref = (i_paddr == pss_pkg::OFS_CORE_REF);
	wire hit_nref = (i_paddr == pss_pkg::OFS_NB_REF);
	wire hit_any  = hit_ctrl | hit_stat | hit_cref | hit_nref;
	wire [2:0] phases_d = ph3_s & ph4_s ? 3'd2 : (ph4_s ? 3'd3 : 3'd4);
	wire [31:0] status_w = {17'h0, svi_pins_q, 2'b00, ngate_q, cgate_q, pgood_q, phases_q,
		serial_q, state_q};
	wire [31:0] rd_mux = hit_ctrl ? {31'h0, hold_q} :
		hit_stat ? status_w :
		hit_cref ? {19'h0, core_ref_q} :
		hit_nref ? {19'h0, nb_ref_q} : 32'h0;

	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= {i_nb_fb_above_ref, i_core_fb_above_ref, i_serial_vid_clock,
				i_serial_vid_data, i_fixed_vid_enable, i_phase4_sense_neg,
				i_phase3_sense_neg, i_interface_select_pin, i_enable_cmp,
				i_nb_driver_supply_ok, i_core_driver_supply_ok, i_bias_por_ok};
			sync_q <= meta_q;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			en_prev_q  <= 1'b0;
			serial_q   <= 1'b0;
			svi_pins_q <= 3'h0;
			svi_core_q <= '0;
			svi_nb_q   <= '0;
		end else begin
			en_prev_q <= bias_s & en_s;
			if (en_rise) begin
				serial_q   <= sel_s;
				svi_pins_q <= sync_q[9:7];
				svi_core_q <= i_serial_core_target;
				svi_nb_q   <= i_serial_nb_target;
			end else if (!bias_s || !en_s) begin
				svi_core_q <= '0;
				svi_nb_q   <= '0;
			end
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			state_q    <= PSS_OFF;
			phases_q   <= 3'd4;
			core_tgt_q <= '0;
			nb_tgt_q   <= '0;
			core_ref_q <= '0;
			nb_ref_q   <= '0;
			dly_q      <= 16'h0;
			us_q       <= 13'h0;
		end else if (!supplies_ok) begin
			state_q    <= PSS_OFF;
			core_tgt_q <= '0;
			nb_tgt_q   <= '0;
			core_ref_q <= '0;
			nb_ref_q   <= '0;
			dly_q      <= 16'h0;
			us_q       <= 13'h0;
		end else begin
			unique case (state_q)
				PSS_OFF: if (start_ok) state_q <= PSS_DETECT;
				PSS_DETECT: begin
					phases_q   <= phases_d;
					core_tgt_q <= serial_q ? svi_core_q : i_parallel_target;
					nb_tgt_q   <= serial_q ? svi_nb_q : '0;
					dly_q      <= 16'h0;
					state_q    <= PSS_DELAY;
				end
				PSS_DELAY: begin
					dly_q <= dly_q + 16'h1;
					if (dly_q == DLY_LAST) begin
						state_q <= PSS_RAMP;
						us_q    <= 13'h0;
					end
				end
				PSS_RAMP: begin
					us_q <= us_tick ? 13'h0 : us_q + 13'h1;
					if (refs_done) begin
						state_q <= PSS_DONE;
					end else if (us_tick) begin
						core_ref_q <= ramp_next(core_ref_q, core_tgt_q);
						nb_ref_q   <= ramp_next(nb_ref_q, nb_tgt_q);
					end
				end
				PSS_DONE: state_q <= PSS_DONE;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn || !supplies_ok || state_q == PSS_OFF || state_q == PSS_DETECT) begin
			cgate_q <= 1'b0;
			ngate_q <= 1'b0;
			pgood_q <= 1'b0;
		end else begin
			if (state_q == PSS_DONE || (in_soft && !cfb_s))
				cgate_q <= 1'b1;
			if (serial_q && (state_q == PSS_DONE || (in_soft && !nfb_s)))
				ngate_q <= 1'b1;
			pgood_q <= (state_q == PSS_DONE);
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			hold_q   <= pss_pkg::CTRL_HOLD_RST;
			prdata_q <= 32'h0;
		end else begin
			if (apb_wr && hit_ctrl)
				hold_q <= i_pwdata[pss_pkg::CTRL_HOLD_BIT];
			prdata_q <= (i_psel && !i_penable && !i_pwrite) ? rd_mux : prdata_q;
		end
	end

	assign o_pready          = 1'b1;
	assign o_pslverr         = apb_acc & ~hit_any;
	assign o_prdata          = prdata_q;
	assign o_core_ref        = core_ref_q;
	assign o_nb_ref          = nb_ref_q;
	assign o_core_gate_en    = cgate_q;
	assign o_nb_gate_en      = ngate_q;
	assign o_nb_regulator_en = serial_q & (state_q != PSS_OFF);
	assign o_serial_vid_mode = serial_q;
	assign o_phase_count     = phases_q;
	assign o_power_good_out  = pgood_q;

	default clocking dc @(posedge i_ref_clk); endclocking
	default disable iff (!i_rstn);

	AST_START_GATED: assert property (
		state_q == PSS_OFF && !start_ok |=> state_q == PSS_OFF)
		else $error("sequencer left shutdown without valid conditions");
	AST_BIAS_FIRST: assert property (
		!bias_s |=> state_q == PSS_OFF)
		else $error("sequencer active without bias");
	AST_DRV_POR: assert property (
		!(cdrv_s && ndrv_s) |=> state_q == PSS_OFF)
		else $error("sequencer active without driver supplies");
	AST_EN_LOW: assert property (
		!en_s |=> !pgood_q && state_q == PSS_OFF)
		else $error("enable low did not force shutdown");
	AST_MODE_LATCH: assert property (
		en_rise |=> serial_q == $past(sel_s))
		else $error("mode not latched on enable rise");
	AST_PHASE_2: assert property (
		state_q == PSS_DETECT && ph3_s && ph4_s && supplies_ok |=> phases_q == 3'd2)
		else $error("two-phase detect wrong");
	AST_PHASE_4: assert property (
		state_q == PSS_DETECT && !ph4_s && supplies_ok |=> phases_q == 3'd4)
		else $error("four-phase detect wrong");
	AST_PVI_NB_OFF: assert property (
		!serial_q |-> (!ngate_q && nb_tgt_q == '0) || state_q == PSS_OFF)
		else $error("secondary rail active in parallel mode");
	AST_TGT_LOAD: assert property (
		state_q == PSS_DETECT && !serial_q && supplies_ok
		|=> core_tgt_q == $past(i_parallel_target))
		else $error("parallel target not loaded at soft-start begin");
	AST_DELAY_FLAT: assert property (
		state_q == PSS_DELAY |-> core_ref_q == '0 && nb_ref_q == '0)
		else $error("reference moved during start delay");
	AST_SLOPE: assert property (
		state_q == PSS_RAMP && supplies_ok && !us_tick |=> $stable(core_ref_q))
		else $error("reference changed off the microsecond tick");
	AST_PGOOD: assert property (
		state_q == PSS_DONE && supplies_ok |=> pgood_q)
		else $error("power good late after ramp end");
	AST_GATE_HOLD: assert property (
		in_soft && cfb_s && !cgate_q && supplies_ok |=> !cgate_q)
		else $error("core gates enabled while feedback above reference");
	AST_PGOOD_LOW: assert property (
		in_soft |-> !pgood_q)
		else $error("power good high during soft-start");
	AST_GATE_ON: assert property (
		in_soft && !cfb_s && supplies_ok |=> cgate_q)
		else $error("core gates not enabled after reference passed feedback");
	AST_GATE_END: assert property (
		state_q == PSS_DONE && supplies_ok |=> cgate_q)
		else $error("core gates off at soft-start end");
	CV_SERIAL_DONE: cover property (serial_q && state_q == PSS_DONE);
	CV_PARALLEL_DONE: cover property (!serial_q && state_q == PSS_DONE);
	CV_PREBIAS: cover property (state_q == PSS_RAMP && cfb_s ##1 !cfb_s);
	CV_DROP: cover property (state_q == PSS_RAMP ##1 state_q == PSS_OFF);
endmodule : pss_sequencer

/* File: verification/pss_analog_model.sv */
// Purpose: feedback comparators of both rails, seen by the sequencer
// Assumes: feedback levels given in reference units
// Notes:   compares on every rising clock edge, so it answers one cycle late
`timescale 1ns/1ps
module pss_analog_model (
	input  wire logic                      i_ref_clk,
	input  wire logic [pss_pkg::REF_W-1:0] i_core_ref,
	input  wire logic [pss_pkg::REF_W-1:0] i_nb_ref,
	input  wire logic [pss_pkg::REF_W-1:0] i_core_fb,
	input  wire logic [pss_pkg::REF_W-1:0] i_nb_fb,
	output logic                           o_core_fb_above_ref,
	output logic                           o_nb_fb_above_ref
);
	always_ff @(posedge i_ref_clk) begin
		o_core_fb_above_ref <= i_core_fb > i_core_ref;
		o_nb_fb_above_ref   <= i_nb_fb > i_nb_ref;
	end
endmodule : pss_analog_model

/* File: verification/tb.sv */
// Purpose: self-checking bench for the soft-start sequencer
// Assumes: short start delay of 50 cycles
// Notes:   one task per scenario
`timescale 1ns/1ps
module tb;
	localparam int DLY = 50;
	logic        clk, rstn, bias, cdrv, ndrv, en, sel, ph3, ph4, vfix, serial_vid_data, serial_vid_clock;
	logic        psel, penable, pwrite, pready, pslverr, cabove, nabove;
	logic        cgate, ngate, nbreg, smode, pgood;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [12:0] cfb, nfb, ptgt, sct, snt, core_ref, nb_ref;
	logic [2:0]  phases;
	logic        err;
	int          failures, check_count;
	pss_sequencer #(.START_DELAY_CYC(DLY)) i_pss_sequencer (.i_ref_clk(clk), .i_rstn(rstn),
		.i_bias_por_ok(bias), .i_core_driver_supply_ok(cdrv), .i_nb_driver_supply_ok(ndrv),
		.i_enable_cmp(en), .i_interface_select_pin(sel), .i_phase3_sense_neg(ph3),
		.i_phase4_sense_neg(ph4), .i_fixed_vid_enable(vfix), .i_serial_vid_data(serial_vid_data),
		.i_serial_vid_clock(serial_vid_clock), .i_core_fb_above_ref(cabove), .i_nb_fb_above_ref(nabove),
		.i_parallel_target(ptgt), .i_serial_core_target(sct), .i_serial_nb_target(snt),
		.i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_pready(pready), .o_pslverr(pslverr), .o_prdata(prdata),
		.o_core_ref(core_ref), .o_nb_ref(nb_ref), .o_core_gate_en(cgate),
		.o_nb_gate_en(ngate), .o_nb_regulator_en(nbreg), .o_serial_vid_mode(smode),
		.o_phase_count(phases), .o_power_good_out(pgood));
	pss_analog_model i_pss_analog_model (.i_ref_clk(clk), .i_core_ref(core_ref),
		.i_nb_ref(nb_ref), .i_core_fb(cfb), .i_nb_fb(nfb), .o_core_fb_above_ref(cabove),
		.o_nb_fb_above_ref(nabove));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd      = prdata;
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	task automatic wait_pg();
		for (int i = 0; i < 20000 && pgood !== 1'b1; i++) @(posedge clk);
	endtask : wait_pg
	task automatic off_all();
		@(posedge clk);
		en <= 1'b0;
		cyc(6);
		chk(pgood, 0);
		chk(core_ref, 0);
	endtask : off_all
	task automatic t_regs_hold();
		chk(pready, 1);
		chk(phases, 4);
		chk(pgood, 0);
		apb(1'b0, 8'h10, 32'h0);
		chk(err, 1);
		chk(rd, 0);
		apb(1'b0, pss_pkg::OFS_CTRL, 32'h0);
		chk(rd, 0);
		apb(1'b1, pss_pkg::OFS_CTRL, 32'h1);
		apb(1'b0, pss_pkg::OFS_CTRL, 32'h0);
		chk(rd, 1);
		@(posedge clk);
		bias <= 1'b1;
		cdrv <= 1'b1;
		en   <= 1'b1;
		ptgt <= 13'h0100;
		cfb  <= 13'h0120;
		cyc(30);
		chk(core_ref, 0);
		apb(1'b0, pss_pkg::OFS_STATUS, 32'h0);
		chk(rd[2:0], 0);
		ndrv <= 1'b1;
		cyc(30);
		apb(1'b0, pss_pkg::OFS_STATUS, 32'h0);
		chk(rd[2:0], 0);
		apb(1'b1, pss_pkg::OFS_CTRL, 32'h0);
	endtask : t_regs_hold
	task automatic t_parallel_prebias();
		cyc(DLY - 10);
		chk(core_ref, 0);
		cyc(2600);
		chk(pgood, 0);
		chk(cgate, 0);
		wait_pg();
		chk(pgood, 1);
		chk(core_ref, 13'h0100);
		chk(cgate, 1);
		chk(phases, 4);
		chk(nbreg, 0);
		chk(nb_ref, 0);
		chk(ngate, 0);
		chk(smode, 0);
		off_all();
	endtask : t_parallel_prebias
	task automatic t_serial();
		@(posedge clk);
		sel  <= 1'b1;
		ph4  <= 1'b1;
		vfix <= 1'b1;
		serial_vid_clock  <= 1'b1;
		cfb  <= 13'h0064;
		sct  <= 13'h0100;
		snt  <= 13'h0080;
		nfb  <= 13'h0000;
		cyc(4);
		en <= 1'b1;
		cyc(10);
		chk(core_ref, 0);
		chk(nb_ref, 0);
		for (int i = 0; i < 5000 && core_ref <= 13'h0071; i++) @(posedge clk);
		cyc(4);
		chk(cgate, 1);
		chk(pgood, 0);
		chk(core_ref, 13'h0075);
		wait_pg();
		chk(core_ref, 13'h0100);
		chk(nb_ref, 13'h0080);
		chk(ngate, 1);
		chk(nbreg, 1);
		chk(smode, 1);
		chk(phases, 3);
		apb(1'b0, pss_pkg::OFS_STATUS, 32'h0);
		chk(rd[14:12], 3'b101);
		chk(rd[7:4], 4'hB);
		apb(1'b0, pss_pkg::OFS_CORE_REF, 32'h0);
		chk(rd, 32'h0000_0100);
		apb(1'b0, pss_pkg::OFS_NB_REF, 32'h0);
		chk(rd, 32'h0000_0080);
		sct <= 13'h0040;
		cyc(300);
		chk(core_ref, 13'h0100);
		off_all();
	endtask : t_serial
	task automatic t_two_phase();
		@(posedge clk);
		sel <= 1'b0;
		ph3 <= 1'b1;
		cyc(4);
		en <= 1'b1;
		cyc(10);
		chk(phases, 2);
		chk(smode, 0);
		chk(nbreg, 0);
		@(posedge clk);
		bias <= 1'b0;
		cyc(6);
		chk(pgood, 0);
		chk(core_ref, 0);
		chk(nb_ref, 0);
	endtask : t_two_phase
	task automatic results();
		$display("comparisons %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : results
	initial begin
		#(4 * 60000);
		failures++;
		results();
	end
	initial begin
		failures = 0; check_count = 0; rstn = 1'b0;
		{bias, cdrv, ndrv, en, sel, ph3, ph4, vfix, serial_vid_data, serial_vid_clock} = 10'h000;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		cfb = '0; nfb = '0; ptgt = '0; sct = '0; snt = '0;
		cyc(5);
		rstn <= 1'b1;
		cyc(2);
		t_regs_hold();
		t_parallel_prebias();
		t_serial();
		t_two_phase();
		results();
	end
endmodule : tb
